/* hdl/adc_general_output_config_regs.sv */
// Summary of operation
// - diag readback bit 5 set sends the SAR result out on serial output.
// - two-bit pad strength fields for serial and data pins; resets 01 and 00.
// - clearing soft sync bit while it and start pin are high gives a one-cycle sync_pulse.
// - soft sync bit, reset high, is ANDed with the start pin value.
// - aux start filter: 10 gives 1.5 clock deglitch, 11 none; 00, 01 reserved.
// - slave readback bit 4 set, with diag readback bit 5 clear, sends converter data out on serial output.
// - clock check bypass bit skips the master clock qualifier check.
// - lane format field: 00 four lanes, 01 two lanes, 10 or 11 one lane.
// - header format bit 5: 0 status header, 1 checksum header; resets to 1.
// - divider field sets bit clock to master clock over two to field power.
module adc_general_output_config_regs
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic spi_reg_out_bit,
    input wire logic sar_result_bit,
    input wire logic adc_data_bit,
    output logic serial_out,
    output logic [1:0] serial_out_pad_strength,
    output logic [1:0] data_lane_pad_strength,
    input wire logic start_pin,
    output logic sync_in,
    output logic sync_pulse,
    input wire logic aux_conversion_start_pin,
    output logic aux_start_filtered,
    input wire logic clock_qualifier_ok,
    output logic clock_ok,
    output logic [3:0] data_output_lanes,
    output logic header_is_crc,
    output logic output_bit_clock,
    output logic [7:0] meter_reference_mux_config
);
    import adc_cfg_pkg::*;

    logic [7:0] general_config_two;
    logic [7:0] general_config_three;
    logic [7:0] output_format_config;
    logic [6:0] divider_count;
    logic [6:0] divider_limit;
    logic write_two;
    logic soft_sync;
    logic deglitch_off;

    assign write_two = reg_wr_en && (reg_addr == GENERAL_CONFIG_TWO_ADDR);
    assign soft_sync = general_config_two[SOFT_SYNC_BIT];
    assign deglitch_off = aux_filter_e'(general_config_three[AUX_FILTER_MSB:AUX_FILTER_LSB]) == FILTER_NONE;
    assign divider_limit = DIVIDER_COUNT_WIDTH'((DIVIDER_ONE << output_format_config[DIVIDER_MSB:DIVIDER_LSB])
        - DIVIDER_ONE);

    // ==========================================================
    // register writes
    // reserved bits are stored as written; host keeps them zero
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            general_config_two <= GENERAL_CONFIG_TWO_RESET;
            general_config_three <= GENERAL_CONFIG_THREE_RESET;
            output_format_config <= OUTPUT_FORMAT_CONFIG_RESET;
            meter_reference_mux_config <= METER_REFERENCE_MUX_CONFIG_RESET;
        end
        else if (reg_wr_en)
        begin
            unique case (reg_addr)
                GENERAL_CONFIG_TWO_ADDR: general_config_two <= reg_wdata;
                GENERAL_CONFIG_THREE_ADDR: general_config_three <= reg_wdata;
                OUTPUT_FORMAT_CONFIG_ADDR: output_format_config <= reg_wdata;
                METER_REFERENCE_MUX_CONFIG_ADDR: meter_reference_mux_config <= reg_wdata;
                default:
                begin
                end
            endcase
        end
    end

    assign serial_out_pad_strength = general_config_two[SERIAL_PAD_MSB:SERIAL_PAD_LSB];
    assign data_lane_pad_strength = general_config_two[DATA_PAD_MSB:DATA_PAD_LSB];
    assign header_is_crc = output_format_config[HEADER_FORMAT_BIT];

    // ==========================================================
    // register reads, one cycle latency
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rdata <= UNMAPPED_READ_VALUE;
        end
        else if (reg_rd_en)
        begin
            unique case (reg_addr)
                GENERAL_CONFIG_TWO_ADDR: reg_rdata <= general_config_two;
                GENERAL_CONFIG_THREE_ADDR: reg_rdata <= general_config_three;
                OUTPUT_FORMAT_CONFIG_ADDR: reg_rdata <= output_format_config;
                METER_REFERENCE_MUX_CONFIG_ADDR: reg_rdata <= meter_reference_mux_config;
                default: reg_rdata <= UNMAPPED_READ_VALUE;
            endcase
        end
    end

    // ==========================================================
    // serial output source; diagnostics outranks slave readback
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            serial_out <= 1'b0;
        end
        else if (general_config_two[DIAG_READBACK_BIT])
        begin
            serial_out <= sar_result_bit;
        end
        else if (general_config_three[SLAVE_READBACK_BIT])
        begin
            serial_out <= adc_data_bit;
        end
        else
        begin
            serial_out <= spi_reg_out_bit;
        end
    end

    // ==========================================================
    // synchronisation
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync_in <= 1'b0;
            sync_pulse <= 1'b0;
        end
        else
        begin
            sync_in <= soft_sync && start_pin;
            sync_pulse <= write_two && !reg_wdata[SOFT_SYNC_BIT] && soft_sync && start_pin;
        end
    end

    // ==========================================================
    // aux start pin filter
    aux_start_filter u_aux_start_filter
    (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin_level(aux_conversion_start_pin),
        .filter_off(deglitch_off),
        .filtered_level(aux_start_filtered)
    );

    // ==========================================================
    // clock qualifier; below the minimum rate the check must be bypassed
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clock_ok <= 1'b0;
        end
        else
        begin
            clock_ok <= general_config_three[CLOCK_BYPASS_BIT] || clock_qualifier_ok;
        end
    end

    // ==========================================================
    // lane selection
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            data_output_lanes <= LANE_MASK_FOUR;
        end
        else
        begin
            unique case (lane_mode_e'(output_format_config[LANE_FORMAT_MSB:LANE_FORMAT_LSB]))
                LANES_FOUR: data_output_lanes <= LANE_MASK_FOUR;
                LANES_TWO: data_output_lanes <= LANE_MASK_TWO;
                LANES_ONE: data_output_lanes <= LANE_MASK_ONE;
                LANES_ONE_ALT: data_output_lanes <= LANE_MASK_ONE;
            endcase
        end
    end

    // ==========================================================
    // bit clock divider; emits a one-cycle tick per divided period
    // a change of the field does not restart the count; a count at or past a lowered limit wraps to zero on the next cycle
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            divider_count <= '0;
            output_bit_clock <= 1'b0;
        end
        else if (divider_count >= divider_limit)
        begin
            divider_count <= '0;
            output_bit_clock <= 1'b1;
        end
        else
        begin
            divider_count <= divider_count + DIVIDER_ONE;
            output_bit_clock <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_diag_source: assert property ($past(general_config_two[DIAG_READBACK_BIT]) |->
        serial_out == $past(sar_result_bit))
        else $error("serial output does not carry the SAR result");

    chk_slave_source: assert property ($past(general_config_three[SLAVE_READBACK_BIT]) &&
        !$past(general_config_two[DIAG_READBACK_BIT]) |-> serial_out == $past(adc_data_bit))
        else $error("serial output does not carry converter data");

    chk_pad_write: assert property (write_two |=>
        serial_out_pad_strength == $past(reg_wdata[SERIAL_PAD_MSB:SERIAL_PAD_LSB]) &&
        data_lane_pad_strength == $past(reg_wdata[DATA_PAD_MSB:DATA_PAD_LSB]))
        else $error("pad strength fields did not follow the write");

    chk_sync_pulse: assert property (write_two && !reg_wdata[SOFT_SYNC_BIT] && soft_sync && start_pin |=>
        sync_pulse ##1 !sync_pulse)
        else $error("soft sync clear did not give a single pulse");

    chk_sync_and: assert property (##1 sync_in == ($past(soft_sync) && $past(start_pin)))
        else $error("sync input is not the AND of soft sync and start pin");

    chk_filter_bypass: assert property ($past(deglitch_off) |->
        aux_start_filtered == $past(aux_conversion_start_pin))
        else $error("aux start not passed straight through with filter off");

    chk_filter_hold: assert property ($changed(aux_start_filtered) && !$past(deglitch_off) &&
        !$past(deglitch_off, 2) |-> aux_start_filtered == $past(aux_conversion_start_pin, 2) &&
        aux_start_filtered == $past(aux_conversion_start_pin, 3))
        else $error("aux start changed without a stable pin level");

    chk_clock_bypass: assert property ($past(general_config_three[CLOCK_BYPASS_BIT]) |-> clock_ok)
        else $error("clock check not bypassed");

    chk_lane_mask: assert property (output_format_config[LANE_FORMAT_MSB] |=>
        data_output_lanes == LANE_MASK_ONE)
        else $error("single lane format gives wrong lanes");

    // a field write can land mid window, so each check looks only one limit ahead
    chk_divide_one: assert property (divider_limit == '0 |=> output_bit_clock)
        else $error("divide by one does not tick every cycle");

    chk_divide_two: assert property (output_bit_clock && divider_limit == DIVIDER_ONE ##1
        divider_limit == DIVIDER_ONE |-> !output_bit_clock ##1 output_bit_clock)
        else $error("divide by two tick spacing wrong");

endmodule

/* common/adc_cfg_pkg.sv */
package adc_cfg_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] GENERAL_CONFIG_TWO_ADDR = 8'h12;
    localparam logic [7:0] GENERAL_CONFIG_THREE_ADDR = 8'h13;
    localparam logic [7:0] OUTPUT_FORMAT_CONFIG_ADDR = 8'h14;
    localparam logic [7:0] METER_REFERENCE_MUX_CONFIG_ADDR = 8'h15;

    localparam logic [7:0] GENERAL_CONFIG_TWO_RESET = 8'h09;
    localparam logic [7:0] GENERAL_CONFIG_THREE_RESET = 8'h80;
    localparam logic [7:0] OUTPUT_FORMAT_CONFIG_RESET = 8'h20;
    localparam logic [7:0] METER_REFERENCE_MUX_CONFIG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // ==========================================================
    // general_config_two fields
    localparam int DIAG_READBACK_BIT = 5;
    localparam int SERIAL_PAD_MSB = 4;
    localparam int SERIAL_PAD_LSB = 3;
    localparam int DATA_PAD_MSB = 2;
    localparam int DATA_PAD_LSB = 1;
    localparam int SOFT_SYNC_BIT = 0;

    // ==========================================================
    // general_config_three fields
    localparam int AUX_FILTER_MSB = 7;
    localparam int AUX_FILTER_LSB = 6;
    localparam int SLAVE_READBACK_BIT = 4;
    localparam int CLOCK_BYPASS_BIT = 0;

    // ==========================================================
    // output_format_config fields
    localparam int LANE_FORMAT_MSB = 7;
    localparam int LANE_FORMAT_LSB = 6;
    localparam int HEADER_FORMAT_BIT = 5;
    localparam int DIVIDER_MSB = 3;
    localparam int DIVIDER_LSB = 1;

    // ==========================================================
    // codes
    typedef enum logic [1:0]
    {
        FILTER_RESERVED_A = 2'b00,
        FILTER_RESERVED_B = 2'b01,
        FILTER_ONE_AND_HALF = 2'b10,
        FILTER_NONE = 2'b11
    } aux_filter_e;

    typedef enum logic [1:0]
    {
        LANES_FOUR = 2'b00,
        LANES_TWO = 2'b01,
        LANES_ONE = 2'b10,
        LANES_ONE_ALT = 2'b11
    } lane_mode_e;

    localparam logic [3:0] LANE_MASK_FOUR = 4'hf;
    localparam logic [3:0] LANE_MASK_TWO = 4'h3;
    localparam logic [3:0] LANE_MASK_ONE = 4'h1;

    // ==========================================================
    // timing: master clock is the block clock
    localparam int AUX_FILTER_MCLK_X10 = 15;
    localparam int AUX_FILTER_CYCLES = (AUX_FILTER_MCLK_X10 + 9) / 10;
    localparam logic [1:0] AUX_FILTER_HOLD = 2'(AUX_FILTER_CYCLES - 1);
    localparam int CLOCK_CHECK_MIN_KHZ = 265;
    localparam int DIVIDER_COUNT_WIDTH = 7;
    localparam logic [6:0] DIVIDER_ONE = 7'h01;

endpackage

/* hdl/aux_start_filter.sv */
module aux_start_filter
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic pin_level,
    input wire logic filter_off,
    output logic filtered_level
);
    import adc_cfg_pkg::*;

    logic last_level;
    logic [1:0] stable_count;

    // ==========================================================
    // stability counter
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            last_level <= 1'b0;
            stable_count <= 2'b00;
        end
        else
        begin
            last_level <= pin_level;
            if (pin_level != last_level)
            begin
                stable_count <= 2'b00;
            end
            else if (stable_count < AUX_FILTER_HOLD)
            begin
                stable_count <= stable_count + 2'b01;
            end
        end
    end

    // ==========================================================
    // output: a level shorter than the hold never passes
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            filtered_level <= 1'b0;
        end
        else if (filter_off)
        begin
            filtered_level <= pin_level;
        end
        else if (stable_count >= AUX_FILTER_HOLD)
        begin
            filtered_level <= last_level;
        end
    end

endmodule

/* tb/ctrl_host_model.sv */
module ctrl_host_model
(
    input wire logic sys_clk,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // ==========================================================
    // released lines flip so a stale value never looks valid
    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
    endtask

    task automatic read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= addr;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~addr;
        #1;
        data = reg_rdata;
    endtask
endmodule

/* tb/tb_adc_general_output_config_regs.sv */
module tb_adc_general_output_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_cfg_pkg::*;

    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr_en, reg_rd_en, sync_in, sync_pulse, aux_start_filtered, clock_ok, header_is_crc;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, meter_reference_mux_config, rd;
    logic spi_reg_out_bit = 1'b0;
    logic sar_result_bit = 1'b0;
    logic adc_data_bit = 1'b0;
    logic start_pin = 1'b0;
    logic aux_conversion_start_pin = 1'b0;
    logic clock_qualifier_ok = 1'b0;
    logic serial_out, output_bit_clock;
    logic [1:0] serial_out_pad_strength, data_lane_pad_strength;
    logic [3:0] data_output_lanes;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    int n_pulse = 0;
    int n_tick = 0;
    int n_aux = 0;
    int t;
    logic [7:0] lane_exp [4] = '{8'h0f, 8'h03, 8'h01, 8'h01};
    logic [7:0] filt_code [4] = '{8'h80, 8'h00, 8'h40, 8'hc0};
    logic [7:0] glitch_exp [4] = '{8'h00, 8'h00, 8'h00, 8'h01};

    adc_general_output_config_regs i_dut
    (
        .sys_clk, .sys_rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
        .spi_reg_out_bit, .sar_result_bit, .adc_data_bit, .serial_out, .serial_out_pad_strength,
        .data_lane_pad_strength, .start_pin, .sync_in, .sync_pulse, .aux_conversion_start_pin,
        .aux_start_filtered, .clock_qualifier_ok, .clock_ok, .data_output_lanes, .header_is_crc,
        .output_bit_clock, .meter_reference_mux_config
    );

    ctrl_host_model i_host
    (
        .sys_clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata
    );

    always #2 sys_clk = ~sys_clk;

    // ==========================================================
    // event counters and the hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        n_pulse += int'(sync_pulse === 1'b1);
        n_tick += int'(output_bit_clock === 1'b1);
        n_aux += int'(aux_start_filtered === 1'b1);
        if (cycles == 10000)
        begin
            n_mismatch++;
            $display("Error timeout after %0d cycles", cycles);
            summarize();
        end
    end

    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
        i_host.read(addr, rd);
        check("rdata", exp, rd);
    endtask

    task automatic serial(input logic spi, input logic sar, input logic adc, input logic [7:0] exp);
        @(posedge sys_clk);
        spi_reg_out_bit <= spi;
        sar_result_bit <= sar;
        adc_data_bit <= adc;
        step(2);
        check("serial_out", exp, 8'(serial_out));
    endtask

    task automatic aux(input int len, input logic [7:0] exp);
        t = n_aux;
        @(posedge sys_clk);
        aux_conversion_start_pin <= 1'b1;
        repeat (len) @(posedge sys_clk);
        aux_conversion_start_pin <= 1'b0;
        step(8);
        check("aux_high", exp, 8'(n_aux - t));
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd_check(GENERAL_CONFIG_TWO_ADDR, 8'h09);
        rd_check(GENERAL_CONFIG_THREE_ADDR, 8'h80);
        rd_check(OUTPUT_FORMAT_CONFIG_ADDR, 8'h20);
        rd_check(METER_REFERENCE_MUX_CONFIG_ADDR, 8'h00);
        rd_check(8'h16, 8'h00);
        check("serial_pad", 8'h01, 8'(serial_out_pad_strength));
        check("data_pad", 8'h00, 8'(data_lane_pad_strength));
        check("lanes", 8'h0f, 8'(data_output_lanes));
        check("header", 8'h01, 8'(header_is_crc));
        check("clock_ok", 8'h00, 8'(clock_ok));
        i_host.write(METER_REFERENCE_MUX_CONFIG_ADDR, 8'ha4);
        rd_check(METER_REFERENCE_MUX_CONFIG_ADDR, 8'ha4);
        check("mux_config", 8'ha4, meter_reference_mux_config);
        // unmapped write must leave the map untouched
        i_host.write(8'h16, 8'h5a);
        rd_check(8'h16, 8'h00);
        rd_check(METER_REFERENCE_MUX_CONFIG_ADDR, 8'ha4);
        for (int i = 0; i < 4; i++)
        begin
            i_host.write(OUTPUT_FORMAT_CONFIG_ADDR, 8'(i << 6));
            step(2);
            check("lanes", lane_exp[i], 8'(data_output_lanes));
            check("header", 8'h00, 8'(header_is_crc));
        end
        // window of 128 cycles holds exactly 128 >> div ticks
        for (int d = 0; d < 8; d++)
        begin
            i_host.write(OUTPUT_FORMAT_CONFIG_ADDR, 8'((d << 1) | 8'h20));
            step(130);
            t = n_tick;
            step(128);
            check("ticks", 8'(128 >> d), 8'(n_tick - t));
        end
        for (int i = 0; i < 4; i++)
        begin
            i_host.write(GENERAL_CONFIG_TWO_ADDR, 8'((i << 3) | ((3 - i) << 1) | 1));
            step(1);
            check("serial_pad", 8'(i), 8'(serial_out_pad_strength));
            check("data_pad", 8'(3 - i), 8'(data_lane_pad_strength));
        end
        serial(1'b1, 1'b0, 1'b1, 8'h01);
        serial(1'b0, 1'b1, 1'b1, 8'h00);
        i_host.write(GENERAL_CONFIG_TWO_ADDR, 8'h29);
        serial(1'b0, 1'b1, 1'b0, 8'h01);
        serial(1'b1, 1'b0, 1'b1, 8'h00);
        i_host.write(GENERAL_CONFIG_THREE_ADDR, 8'h90);
        serial(1'b0, 1'b0, 1'b1, 8'h00);
        i_host.write(GENERAL_CONFIG_TWO_ADDR, 8'h09);
        serial(1'b0, 1'b0, 1'b1, 8'h01);
        serial(1'b1, 1'b1, 1'b0, 8'h00);
        @(posedge sys_clk);
        start_pin <= 1'b1;
        step(2);
        check("sync_in", 8'h01, 8'(sync_in));
        t = n_pulse;
        i_host.write(GENERAL_CONFIG_TWO_ADDR, 8'h08);
        step(3);
        check("sync_pulses", 8'h01, 8'(n_pulse - t));
        check("sync_in", 8'h00, 8'(sync_in));
        i_host.write(GENERAL_CONFIG_TWO_ADDR, 8'h08);
        step(3);
        check("sync_pulses", 8'h01, 8'(n_pulse - t));
        for (int i = 0; i < 4; i++)
        begin
            i_host.write(GENERAL_CONFIG_THREE_ADDR, filt_code[i]);
            aux(1, glitch_exp[i]);
            aux(4, 8'h04);
        end
        i_host.write(GENERAL_CONFIG_THREE_ADDR, 8'h81);
        step(2);
        check("clock_ok", 8'h01, 8'(clock_ok));
        i_host.write(GENERAL_CONFIG_THREE_ADDR, 8'h80);
        @(posedge sys_clk);
        clock_qualifier_ok <= 1'b1;
        step(2);
        check("clock_ok", 8'h01, 8'(clock_ok));
        summarize();
    end
endmodule
